// ==== rradc_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RRADC_MAP_SVH
`define RRADC_MAP_SVH

`define RRADC_ADDR_REF_CTRL    4'h0
`define RRADC_ADDR_CONV_CTRL   4'h1
`define RRADC_ADDR_RESULT_HI   4'h2
`define RRADC_ADDR_RESULT_LO   4'h3
`define RRADC_ADDR_ROUTE_STAT  4'h4
`define RRADC_ADDR_COMP_CTRL   4'h5

`define RRADC_REF_CTRL_RESET   8'h00
`define RRADC_CONV_CTRL_RESET  8'h00
`define RRADC_COMP_CTRL_RESET  8'h00

// reference control fields
`define RRADC_LADDER_EN_BIT    7
`define RRADC_PIN_OE_BIT       6
`define RRADC_RANGE_BIT        5
`define RRADC_SOURCE_BIT       4
`define RRADC_LEVEL_MSB        3
`define RRADC_LEVEL_LSB        0

// converter control fields
`define RRADC_CFG_HI_BIT       7
`define RRADC_CFG_LO_BIT       6
`define RRADC_CHAN_MSB         5
`define RRADC_CHAN_LSB         2
`define RRADC_START_BIT        1
`define RRADC_ENABLE_BIT       0

// comparator select, done flag and done interrupt enable fields
`define RRADC_C1_SEL_BIT       0
`define RRADC_C2_SEL_BIT       1
`define RRADC_DONE_FLAG_BIT    2
`define RRADC_DONE_IE_BIT      3

// successive approximation timing
`define RRADC_RESULT_BITS      10
`define RRADC_STEP_NS          100
`define RRADC_CLK_NS           10
`define RRADC_STEP_CYCLES      (`RRADC_STEP_NS / `RRADC_CLK_NS)

`endif

// ==== rradc_monitor.sv ====
// assertions on the routing, register and converter ports
`timescale 1ns/1ps
`default_nettype none
module rradc_monitor (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        sleeping,
    input wire logic [15:0] analog_in_select,
    input wire logic        ladder_on,
    input wire logic        ladder_range_select,
    input wire logic [3:0]  ladder_level_select,
    input wire logic        ladder_from_pins,
    input wire logic [1:0]  comp_ref_pos,
    input wire logic [1:0]  comp_ref_neg,
    input wire logic [1:0]  conv_ref_pos,
    input wire logic [1:0]  port_a_pin3,
    input wire logic [1:0]  conv_ref_neg,
    input wire logic [1:0]  port_a_pin2,
    input wire logic        comp_one_ladder,
    input wire logic        ladder_current,
    input wire logic        irq,
    input wire logic        wake
);
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic ref_wr;
    assign ref_wr = write && !waitrequest && address == 4'h0;

    property p_ladder_on; ref_wr |-> ##2 ladder_on == $past(writedata[7], 2);
    endproperty
    a_ladder_on: assert property (p_ladder_on) else $error("ladder on wrong");
    property p_level;
        ref_wr |-> ##2 {ladder_range_select, ladder_level_select}
            == $past({writedata[5], writedata[3:0]}, 2);
    endproperty
    a_level: assert property (p_level) else $error("ladder tap wrong");
    property p_source; ref_wr |-> ##2 ladder_from_pins == $past(writedata[4], 2);
    endproperty
    a_source: assert property (p_source) else $error("source wrong");
    property p_pin3; conv_ref_pos == 2'b01 |-> port_a_pin3 == 2'b10; endproperty
    a_pin3: assert property (p_pin3) else $error("pin3 wrong");
    property p_cneg; comp_ref_neg == 2'b10 |-> comp_ref_pos == 2'b01; endproperty
    a_cneg: assert property (p_cneg) else $error("comp neg wrong");
    property p_pin2; conv_ref_neg == 2'b10 |-> port_a_pin2 == 2'b11; endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 wrong");
    property p_current; comp_one_ladder |-> ladder_current; endproperty
    a_current: assert property (p_current) else $error("current off");
    property p_wake; wake == (irq && $past(sleeping)); endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_one_input; $onehot0(analog_in_select); endproperty
    a_one_input: assert property (p_one_input) else $error("inputs");
    property p_result;
        read && !waitrequest && address == 4'h2 |-> readdata[31:2] == 30'h0;
    endproperty
    a_result: assert property (p_result) else $error("result high wide");

    // ---------------------------------------------------------------
    // covers
    // ---------------------------------------------------------------
    c_ref_wr: cover property (ref_wr);
    c_wake: cover property (irq && sleeping);
    c_res: cover property (read && !waitrequest && address == 4'h3);
endmodule // rradc_monitor

bind rradc_top rradc_monitor mon_u (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sleeping(sleeping),
    .analog_in_select(analog_in_select), .ladder_on(ladder_on),
    .ladder_range_select(ladder_range_select),
    .ladder_level_select(ladder_level_select),
    .ladder_from_pins(ladder_from_pins), .comp_ref_pos(comp_ref_pos),
    .comp_ref_neg(comp_ref_neg), .conv_ref_pos(conv_ref_pos),
    .port_a_pin3(port_a_pin3), .conv_ref_neg(conv_ref_neg),
    .port_a_pin2(port_a_pin2), .comp_one_ladder(comp_one_ladder),
    .ladder_current(ladder_current), .irq(irq), .wake(wake)
);
`default_nettype wire

// ==== rradc_pkg.sv ====
// types shared by the reference routing and converter front end
package rradc_pkg;

    typedef enum logic [1:0] {
        RRADC_REF_SUPPLY  = 2'b00,
        RRADC_REF_EXT_POS = 2'b01,
        RRADC_REF_EXT_NEG = 2'b10,
        RRADC_REF_GROUND  = 2'b11
    } rradc_ref_e;

    typedef enum logic [1:0] {
        RRADC_PIN_IO     = 2'b00,
        RRADC_PIN_LADDER = 2'b01,
        RRADC_PIN_VREF_P = 2'b10,
        RRADC_PIN_VREF_N = 2'b11
    } rradc_pin_e;

    typedef enum logic [1:0] {
        RRADC_IDLE  = 2'b00,
        RRADC_SETUP = 2'b01,
        RRADC_STEP  = 2'b10,
        RRADC_DONE  = 2'b11
    } rradc_state_e;

endpackage : rradc_pkg

// ==== rradc_sar.sv ====
// successive approximation engine for the 10-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "rradc_map.svh"

module rradc_sar (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        cmp_above,
    output logic [9:0]       trial,
    output logic [9:0]       result,
    output logic             done,
    output logic             busy
);
    rradc_pkg::rradc_state_e state_q;
    logic [9:0]              bit_q;
    logic [3:0]              tick_q;

    assign busy = (state_q != rradc_pkg::RRADC_IDLE);

    // ------------------------------------------------------------
    // bit-by-bit search
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rradc_pkg::RRADC_IDLE;
            bit_q   <= 10'h000;
            trial   <= 10'h000;
            result  <= 10'h000;
            tick_q  <= 4'h0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state_q <= rradc_pkg::RRADC_IDLE;
            end else begin
                case (state_q)
                    rradc_pkg::RRADC_IDLE: begin
                        if (start) begin
                            state_q <= rradc_pkg::RRADC_SETUP;
                        end
                    end
                    rradc_pkg::RRADC_SETUP: begin
                        bit_q   <= 10'h200;
                        trial   <= 10'h200;
                        tick_q  <= 4'h0;
                        state_q <= rradc_pkg::RRADC_STEP;
                    end
                    rradc_pkg::RRADC_STEP: begin
                        // comparator needs time to settle per bit
                        if (tick_q == 4'(`RRADC_STEP_CYCLES - 1)) begin
                            tick_q <= 4'h0;
                            if (!cmp_above) begin
                                trial <= (trial & ~bit_q) | (bit_q >> 1);
                            end else begin
                                trial <= trial | (bit_q >> 1);
                            end
                            bit_q <= bit_q >> 1;
                            if (bit_q == 10'h001) begin
                                state_q <= rradc_pkg::RRADC_DONE;
                            end
                        end else begin
                            tick_q <= tick_q + 4'h1;
                        end
                    end
                    rradc_pkg::RRADC_DONE: begin
                        result  <= trial;
                        done    <= 1'b1;
                        state_q <= rradc_pkg::RRADC_IDLE;
                    end
                    default: state_q <= rradc_pkg::RRADC_IDLE;
                endcase
            end
        end
    end
endmodule // rradc_sar
`default_nettype wire

// ==== rradc_top.sv ====
// reference routing, control register and converter front end
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rradc_map.svh"

// Contract
// - sixteen config combinations drive reference routing
// - eight-bit reference control, read write, resets zero
// - ten-bit successive approximation into result pair
// - exactly one analog input to sample
// - software picks internal or external reference
// - completion raises interrupt request
// - completion interrupt wakes device from sleep
// - ladder enable bit enables ladder alone
// - range bit and four-bit tap select
// - source bit picks supply or pins
// - comparator one select picks ladder, current
module rradc_top (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        cmp_above,
    input  wire logic        sleeping,
    output logic [15:0]      analog_in_select,
    output logic [9:0]       dac_trial,
    output logic             ladder_on,
    output logic             ladder_current,
    output logic             ladder_range_select,
    output logic [3:0]       ladder_level_select,
    output logic             ladder_from_pins,
    output logic [1:0]       comp_ref_pos,
    output logic [1:0]       comp_ref_neg,
    output logic [1:0]       conv_ref_pos,
    output logic [1:0]       conv_ref_neg,
    output logic [1:0]       port_a_pin2,
    output logic [1:0]       port_a_pin3,
    output logic             comp_one_ladder,
    output logic             comp_two_ladder,
    output logic             irq,
    output logic             wake
);
    logic [7:0]  reference_control_q;
    logic [7:0]  conv_ctrl_q;
    logic [7:0]  comp_ctrl_q;
    logic [9:0]  result_q;
    logic        done_flag_q;
    logic        ack_q;
    logic        go_q;
    logic        sar_done;
    logic        sar_busy;
    logic [9:0]  sar_result;
    logic [9:0]  sar_trial;
    logic        wr_hit;
    logic        rd_hit;
    logic [3:0]  route_key;
    logic [1:0]  cp_d;
    logic [1:0]  cn_d;
    logic [1:0]  ap_d;
    logic [1:0]  an_d;
    logic [1:0]  p2_d;
    logic [1:0]  p3_d;
    logic [31:0] rd_d;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // one wait state: writes land only while waitrequest is low
    assign wr_hit = write && ack_q;
    assign rd_hit = read && !ack_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && !ack_q);
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (address == `RRADC_ADDR_REF_CTRL) begin
            rd_d = {24'h000000, reference_control_q};
        end else if (address == `RRADC_ADDR_CONV_CTRL) begin
            rd_d = {24'h000000, conv_ctrl_q[7:2], go_q, conv_ctrl_q[0]};
        end else if (address == `RRADC_ADDR_RESULT_HI) begin
            rd_d = {30'h00000000, result_q[9:8]};
        end else if (address == `RRADC_ADDR_RESULT_LO) begin
            rd_d = {24'h000000, result_q[7:0]};
        end else if (address == `RRADC_ADDR_ROUTE_STAT) begin
            rd_d = {20'h00000, p3_d, p2_d, an_d, ap_d, cn_d, cp_d};
        end else if (address == `RRADC_ADDR_COMP_CTRL) begin
            rd_d = {28'h0000000, comp_ctrl_q[3], done_flag_q,
                    comp_ctrl_q[1:0]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            readdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // reference control storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reference_control_q <= `RRADC_REF_CTRL_RESET;
        end else if (wr_hit && address == `RRADC_ADDR_REF_CTRL) begin
            reference_control_q <= writedata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_ctrl_q <= `RRADC_CONV_CTRL_RESET;
        end else if (wr_hit && address == `RRADC_ADDR_CONV_CTRL) begin
            conv_ctrl_q <= writedata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comp_ctrl_q <= `RRADC_COMP_CTRL_RESET;
        end else if (wr_hit && address == `RRADC_ADDR_COMP_CTRL) begin
            comp_ctrl_q <= writedata[7:0];
        end
    end

    // start bit: set by software, cleared at completion, by software or when the converter is disabled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            go_q <= 1'b0;
        end else if (sar_done) begin
            go_q <= 1'b0;
        end else if (wr_hit && address == `RRADC_ADDR_CONV_CTRL) begin
            go_q <= writedata[`RRADC_START_BIT]
                    && conv_ctrl_q[`RRADC_ENABLE_BIT];
        end else if (!conv_ctrl_q[`RRADC_ENABLE_BIT]) begin
            go_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // converter
    // ------------------------------------------------------------
    // engine searches ten bits
    rradc_sar u_sar (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (go_q && !sar_busy && !sar_done),
        .abort     (!go_q && sar_busy),
        .cmp_above (cmp_above),
        .trial     (sar_trial),
        .result    (sar_result),
        .done      (sar_done),
        .busy      (sar_busy)
    );

    // result pair updated only on completion
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= 10'h000;
        end else if (sar_done) begin
            result_q <= sar_result;
        end
    end

    // sticky done flag, set beats clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_q <= 1'b0;
        end else if (sar_done) begin
            done_flag_q <= 1'b1;
        end else if (wr_hit && address == `RRADC_ADDR_COMP_CTRL
                     && !writedata[`RRADC_DONE_FLAG_BIT]) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= done_flag_q && comp_ctrl_q[`RRADC_DONE_IE_BIT];
            wake <= done_flag_q && comp_ctrl_q[`RRADC_DONE_IE_BIT]
                    && sleeping;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            analog_in_select <= 16'h0000;
            dac_trial        <= 10'h000;
        end else begin
            analog_in_select <= conv_ctrl_q[`RRADC_ENABLE_BIT]
                ? (16'h0001 << conv_ctrl_q[`RRADC_CHAN_MSB:`RRADC_CHAN_LSB])
                : 16'h0000;
            dac_trial <= sar_trial;
        end
    end

    // ------------------------------------------------------------
    // reference routing
    // ------------------------------------------------------------
    // decode from stored bits
    assign route_key = {conv_ctrl_q[`RRADC_CFG_HI_BIT],
                        conv_ctrl_q[`RRADC_CFG_LO_BIT],
                        reference_control_q[`RRADC_SOURCE_BIT],
                        reference_control_q[`RRADC_PIN_OE_BIT]};

    // comparator reference from supply or pins
    always_comb begin
        cp_d = reference_control_q[`RRADC_SOURCE_BIT]
            ? rradc_pkg::RRADC_REF_EXT_POS : rradc_pkg::RRADC_REF_SUPPLY;
        cn_d = (route_key[1] && !route_key[0])
            ? rradc_pkg::RRADC_REF_EXT_NEG : rradc_pkg::RRADC_REF_GROUND;
        ap_d = route_key[2]
            ? rradc_pkg::RRADC_REF_EXT_POS : rradc_pkg::RRADC_REF_SUPPLY;
        an_d = route_key[3]
            ? rradc_pkg::RRADC_REF_EXT_NEG : rradc_pkg::RRADC_REF_GROUND;
        p3_d = (route_key[3:2] == 2'b00 && !route_key[1])
            || (route_key[3:2] == 2'b10 && !route_key[1])
            ? rradc_pkg::RRADC_PIN_IO : rradc_pkg::RRADC_PIN_VREF_P;
        if (route_key[3]) begin
            p2_d = rradc_pkg::RRADC_PIN_VREF_N;
        end else if (route_key[0]) begin
            p2_d = rradc_pkg::RRADC_PIN_LADDER;
        end else if (route_key[1]) begin
            p2_d = rradc_pkg::RRADC_PIN_VREF_N;
        end else begin
            p2_d = rradc_pkg::RRADC_PIN_IO;
        end
        // external negative pin wins over ladder output
        if (route_key[3] && route_key[1]) begin
            cn_d = rradc_pkg::RRADC_REF_EXT_NEG;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comp_ref_pos <= 2'b00;
            comp_ref_neg <= 2'b11;
            conv_ref_pos <= 2'b00;
            conv_ref_neg <= 2'b11;
            port_a_pin2  <= 2'b00;
            port_a_pin3  <= 2'b00;
        end else begin
            comp_ref_pos <= cp_d;
            comp_ref_neg <= cn_d;
            conv_ref_pos <= ap_d;
            conv_ref_neg <= an_d;
            port_a_pin2  <= p2_d;
            port_a_pin3  <= p3_d;
        end
    end

    // ------------------------------------------------------------
    // ladder control
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ladder_on           <= 1'b0;
            ladder_current      <= 1'b0;
            ladder_range_select <= 1'b0;
            ladder_level_select <= 4'h0;
            ladder_from_pins    <= 1'b0;
            comp_one_ladder     <= 1'b0;
            comp_two_ladder     <= 1'b0;
        end else begin
            ladder_on <= reference_control_q[`RRADC_LADDER_EN_BIT];
            ladder_range_select <= reference_control_q[`RRADC_RANGE_BIT];
            ladder_level_select <=
                reference_control_q[`RRADC_LEVEL_MSB:`RRADC_LEVEL_LSB];
            ladder_from_pins <= reference_control_q[`RRADC_SOURCE_BIT];
            comp_one_ladder <= comp_ctrl_q[`RRADC_C1_SEL_BIT];
            comp_two_ladder <= comp_ctrl_q[`RRADC_C2_SEL_BIT];
            // no divider current unless a comparator uses it
            ladder_current  <= comp_ctrl_q[`RRADC_C1_SEL_BIT]
                               || comp_ctrl_q[`RRADC_C2_SEL_BIT];
        end
    end
endmodule // rradc_top
`default_nettype wire

// ==== rradc_top_bench.sv ====
// self-checking bench for the routing and converter front end
`timescale 1ns/1ps
`default_nettype none
module rradc_top_bench;
    logic        clock, rst_n, read, write, cmp_above, sleeping;
    logic [3:0]  address, ladder_level_select;
    logic [31:0] writedata, readdata;
    logic        waitrequest, ladder_on, ladder_current, ladder_range_select;
    logic        ladder_from_pins, comp_one_ladder, comp_two_ladder, irq, wake;
    logic [15:0] analog_in_select;
    logic [9:0]  dac_trial, target;
    logic [1:0]  comp_ref_pos, comp_ref_neg, conv_ref_pos, conv_ref_neg;
    logic [1:0]  port_a_pin2, port_a_pin3;
    int          bad_count, n_tests;

    rradc_top dut_u (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cmp_above(cmp_above),
        .sleeping(sleeping), .analog_in_select(analog_in_select),
        .dac_trial(dac_trial), .ladder_on(ladder_on),
        .ladder_current(ladder_current),
        .ladder_range_select(ladder_range_select),
        .ladder_level_select(ladder_level_select),
        .ladder_from_pins(ladder_from_pins), .comp_ref_pos(comp_ref_pos),
        .comp_ref_neg(comp_ref_neg), .conv_ref_pos(conv_ref_pos),
        .conv_ref_neg(conv_ref_neg), .port_a_pin2(port_a_pin2),
        .port_a_pin3(port_a_pin3), .comp_one_ladder(comp_one_ladder),
        .comp_two_ladder(comp_two_ladder), .irq(irq), .wake(wake)
    );

    always #5 clock = ~clock;
    // analog input sits at target: comparator says input >= trial
    always @(posedge clock) cmp_above <= (dac_trial <= target);

    // ---------------------------------------------------------------
    // bus and compare helpers
    // ---------------------------------------------------------------
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string w);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(w, e, q);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd(4'h0, 32'h0, "ref reset");
        chk("pins idle", 4'h0, {port_a_pin3, port_a_pin2});
        $display("test reset done");
    endtask

    task automatic t_ref;
        logic [7:0] v [4];
        v = '{8'ha5, 8'h5a, 8'hff, 8'h00};
        foreach (v[i]) begin
            wr(4'h0, v[i]);
            rd(4'h0, {24'h0, v[i]}, "ref readback");
            #1;
            chk("ladder on", v[i][7], ladder_on);
            chk("range", v[i][5], ladder_range_select);
            chk("level", v[i][3:0], ladder_level_select);
            chk("from pins", v[i][4], ladder_from_pins);
        end
        // unmapped place ignores writes and reads zero
        wr(4'h7, 8'hff);
        rd(4'h7, 32'h0, "unmapped");
        rd(4'h0, 32'h0, "ref kept");
        $display("test reference register done");
    endtask

    task automatic t_route;
        logic [3:0]  c;
        logic [11:0] e;
        for (int k = 0; k < 16; k++) begin
            // c = {cfg hi, cfg lo, source, pin oe}
            c = 4'(k);
            wr(4'h0, {1'b0, c[0], 1'b0, c[1], 4'h0});
            wr(4'h1, {c[3], c[2], 6'h00});
            e[11:10] = (c[1] || c[2]) ? 2'b10 : 2'b00;
            e[9:8] = (c[0] && !c[3]) ? 2'b01 : (c[1] || c[3]) ? 2'b11 : 2'b00;
            e[7:6] = c[3] ? 2'b10 : 2'b11;
            e[5:4] = {1'b0, c[2]};
            e[3:2] = (c[1] && !(c[0] && !c[3])) ? 2'b10 : 2'b11;
            e[1:0] = {1'b0, c[1]};
            repeat (2) @(posedge clock);
            #1;
            chk("routing", e, {port_a_pin3, port_a_pin2, conv_ref_neg,
                conv_ref_pos, comp_ref_neg, comp_ref_pos});
            rd(4'h4, {20'h0, e}, "route status");
        end
        $display("test routing table done");
    endtask

    task automatic t_comp;
        for (int j = 0; j < 4; j++) begin
            wr(4'h5, 8'(j));
            repeat (2) @(posedge clock);
            #1;
            chk("comp one", j[0], comp_one_ladder);
            chk("comp two", j[1], comp_two_ladder);
            chk("current", j != 0, ladder_current);
        end
        $display("test comparator select done");
    endtask

    task automatic t_conv;
        target = 10'h2b6;
        wr(4'h0, 8'h00);
        wr(4'h5, 8'h08);
        sleeping <= 1'b1;
        wr(4'h1, 8'h15);
        repeat (2) @(posedge clock);
        #1;
        chk("input select", 16'h0020, analog_in_select);
        wr(4'h1, 8'h17);
        for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clock);
        #1;
        chk("irq", 1'b1, irq);
        chk("wake", 1'b1, wake);
        rd(4'h2, {30'h0, target[9:8]}, "result high");
        rd(4'h3, {24'h0, target[7:0]}, "result low");
        rd(4'h1, 32'h15, "start cleared");
        rd(4'h5, 32'h0c, "done flag");
        wr(4'h5, 8'h08);
        sleeping <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("irq cleared", 2'b00, {irq, wake});
        // clearing start mid-run aborts and keeps the old result
        wr(4'h1, 8'h17);
        wr(4'h1, 8'h15);
        repeat (150) @(posedge clock);
        #1;
        chk("abort irq", 1'b0, irq);
        rd(4'h3, {24'h0, target[7:0]}, "result kept");
        rd(4'h1, 32'h15, "abort cleared");
        // start is cleared once the converter is off
        wr(4'h1, 8'h02);
        rd(4'h1, 32'h0, "start needs enable");
        chk("input off", 16'h0000, analog_in_select);
        $display("test conversion done");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #50000;
        bad_count++;
        summarize();
    end

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        sleeping = 1'b0;
        target = 10'h000;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_ref();
        t_route();
        t_comp();
        t_conv();
        summarize();
    end
endmodule // rradc_top_bench
`default_nettype wire
